// ### common/ast_pkg.sv
package ast_pkg;

  localparam logic [7:0] AST_OFS_DATA  = 8'h00;
  localparam logic [7:0] AST_OFS_FLAG  = 8'h04;
  localparam logic [7:0] AST_OFS_DIVI  = 8'h08;
  localparam logic [7:0] AST_OFS_DIVF  = 8'h0C;
  localparam logic [7:0] AST_OFS_LINE  = 8'h10;
  localparam logic [7:0] AST_OFS_CTRL  = 8'h14;
  localparam logic [7:0] AST_OFS_LEVEL = 8'h18;
  localparam logic [7:0] AST_OFS_STAT  = 8'h1C;

  localparam int unsigned AST_DEPTH = 16;
  localparam logic [4:0]  AST_FULL_FEN  = 5'h10;
  localparam logic [4:0]  AST_FULL_HOLD = 5'h01;
  localparam logic [22:0] AST_FRAC_ONE  = 23'h000040;
  localparam logic [3:0]  AST_LAST16 = 4'hF;
  localparam logic [3:0]  AST_LAST8  = 4'h7;
  localparam logic [3:0]  AST_HALF16 = 4'h7;
  localparam logic [3:0]  AST_HALF8  = 4'h3;

  typedef struct packed {
    logic       sps;
    logic [1:0] wlen;
    logic       fen;
    logic       stp2;
    logic       eps;
    logic       pen;
    logic       brk;
  } ast_line_t;

  typedef struct packed {
    logic ctsen;
    logic rtsen;
    logic rts;
    logic receive_path_enable;
    logic transmit_path_enable;
    logic eot;
    logic high_speed_sample_select;
    logic en;
  } ast_ctrl_t;

  typedef struct packed {
    logic [2:0] rx;
    logic [2:0] tx;
  } ast_level_t;

  typedef struct packed {
    logic       oe;
    logic       be;
    logic       pe;
    logic       fe;
    logic [7:0] data;
  } ast_rxw_t;

  typedef enum logic [4:0] {
    AST_TX_IDLE  = 5'h01,
    AST_TX_START = 5'h02,
    AST_TX_DATA  = 5'h04,
    AST_TX_PAR   = 5'h08,
    AST_TX_STOP  = 5'h10
  } ast_tx_st_t;

  typedef enum logic [4:0] {
    AST_RX_IDLE  = 5'h01,
    AST_RX_START = 5'h02,
    AST_RX_DATA  = 5'h04,
    AST_RX_PAR   = 5'h08,
    AST_RX_STOP  = 5'h10
  } ast_rx_st_t;

  localparam ast_ctrl_t  AST_CTRL_RST  = 8'h18;
  localparam ast_line_t  AST_LINE_RST  = 8'h00;
  localparam ast_level_t AST_LEVEL_RST = 6'h12;
  localparam logic [15:0] AST_DIVI_RST = 16'h0000;
  localparam logic [5:0]  AST_DIVF_RST = 6'h00;

  function automatic logic ast_par(input logic [7:0] d, input ast_line_t l);
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - l.wlen));
    if (l.sps) begin
      ast_par = ~l.eps;
    end else begin
      ast_par = l.eps ? ^m : ~^m;
    end
  endfunction

  function automatic logic [4:0] ast_lvl(input logic [2:0] sel);
    case (sel)
      3'h0:    ast_lvl = 5'h02;
      3'h1:    ast_lvl = 5'h04;
      3'h2:    ast_lvl = 5'h08;
      3'h3:    ast_lvl = 5'h0C;
      3'h4:    ast_lvl = 5'h0E;
      default: ast_lvl = 5'h08;
    endcase
  endfunction

endpackage

// ### src/ast_baud.sv
`timescale 1ns/100ps
module ast_baud
  import ast_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [21:0] div,
  output logic             tick
);
  typedef struct packed {
    logic [22:0] acc;
    logic        tick;
  } ast_baud_st_t;

  ast_baud_st_t s;
  ast_baud_st_t next_s;
  logic [22:0]  sum;

  // Fractional divider in 1/64 steps: one tick per div/64 clocks on average
  always_comb begin
    next_s = s;
    sum = s.acc + AST_FRAC_ONE;
    next_s.tick = 1'b0;
    if (div == 22'h0) begin
      next_s.acc = 23'h0;
    end else if (sum >= {1'b0, div}) begin
      next_s.acc = sum - {1'b0, div};
      next_s.tick = 1'b1;
    end else begin
      next_s.acc = sum;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule

// ### src/ast_fifo.sv
`timescale 1ns/100ps
module ast_fifo
  import ast_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         fen,
  input  wire logic         push,
  input  wire logic [W-1:0] wdata,
  input  wire logic         pop,
  output logic [W-1:0]      rdata,
  output logic [4:0]        count,
  output logic              full,
  output logic              empty
);
  typedef struct packed {
    logic [AST_DEPTH-1:0][W-1:0] mem;
    logic [3:0]                  wp;
    logic [3:0]                  rp;
    logic [4:0]                  cnt;
  } ast_fifo_st_t;

  ast_fifo_st_t s;
  ast_fifo_st_t next_s;
  logic         do_push;
  logic         do_pop;

  // Without fen the store acts as a single holding register
  assign full  = s.cnt >= (fen ? AST_FULL_FEN : AST_FULL_HOLD);
  assign empty = s.cnt == 5'h00;
  assign rdata = s.mem[s.rp];
  assign count = s.cnt;

  always_comb begin
    next_s = s;
    do_push = push && !full;
    do_pop = pop && !empty;
    if (do_push) begin
      next_s.mem[s.wp] = wdata;
      next_s.wp = s.wp + 4'h1;
    end
    if (do_pop) begin
      next_s.rp = s.rp + 4'h1;
    end
    next_s.cnt = s.cnt + {4'h0, do_push} - {4'h0, do_pop};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end
endmodule

// ### src/ast_transceiver.sv
// Contract
// - After reset both transmit and receive path enables are set.
// - Clearing port enable lets the current character finish before halting.
// - Transmit start bit, data LSB first, optional parity, then stop bits.
// - Receiver assembles a character only after a valid start bit.
// - Overrun, parity, framing and break flags stored with each received character.
// - Separate transmit and receive FIFOs of sixteen entries.
// - FIFOs disabled means single-entry holding registers each way.
// - Trigger thresholds of 1/8, 1/4, 1/2, 3/4 and 7/8 of depth.
// - Character length of 5, 6, 7 or 8 data bits.
// - Even, odd, stick or no parity, generated and checked.
// - One or two stop bits as configured.
// - Receive DMA single request when data held, burst at trigger level.
// - Transmit DMA single request when space free, burst at trigger level.
// - Programmable baud generator driven from the system clock.
// - Interrupts on FIFO trigger level and on end of transmission.
// - RTS and CTS hardware handshaking; remote honours them.
// - 16.6 divisor gives tick at 16x bit rate, or 8x with high-speed select.
// - Divisor and format take effect only on line-format write.
// - Start confirmed low at mid-bit, later bits sampled one period apart.
// - Framing error when stop-bit sample is not high.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/100ps
module ast_transceiver
  import ast_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RSTN,
  input  wire logic        CE,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  output logic             TXD,
  input  wire logic        RXD,
  input  wire logic        CTS_N,
  output logic             RTS_N,
  output logic             DMA_RX_SREQ,
  output logic             DMA_RX_BREQ,
  output logic             DMA_TX_SREQ,
  output logic             DMA_TX_BREQ,
  output logic             RX_INT,
  output logic             TX_INT
);
  typedef struct packed {
    ast_ctrl_t   ctrl;
    ast_line_t   line;
    ast_line_t   act_line;
    logic [15:0] divi;
    logic [5:0]  divf;
    logic [21:0] act_div;
    ast_level_t  lvl;
    ast_tx_st_t  tx_st;
    logic [3:0]  tx_sub;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic        tx_par;
    ast_rx_st_t  rx_st;
    logic [3:0]  rx_sub;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_zero;
    logic        rx_pe;
    logic        rx_prev;
    logic        oe_pend;
    logic        oe_stat;
    logic [31:0] rdata;
    logic        txd;
    logic        rts_n;
    logic        rx_sreq;
    logic        rx_breq;
    logic        tx_sreq;
    logic        tx_breq;
    logic        rx_int;
    logic        tx_int;
  } ast_top_st_t;

  ast_top_st_t s;
  ast_top_st_t next_s;

  logic        tick;
  logic        tx_push;
  logic        tx_pop;
  logic [7:0]  tx_rdata;
  logic [4:0]  tx_cnt;
  logic        tx_full;
  logic        tx_empty;
  logic        rx_push;
  logic        rx_pop;
  ast_rxw_t    rx_wdata;
  logic [11:0] rx_rdata;
  logic [4:0]  rx_cnt;
  logic        rx_full;
  logic        rx_empty;
  logic [3:0]  last;
  logic [3:0]  half;
  logic        tx_end;
  logic        rx_smp;
  logic [2:0]  top_bit;
  logic [4:0]  rx_lvl;
  logic [4:0]  tx_lvl;
  logic        busy;

  ast_baud u_baud (
    .clk   (REF_CLK),
    .rst_n (RSTN),
    .ce    (CE),
    .div   (s.act_div),
    .tick  (tick)
  );

  ast_fifo #(.W(8)) u_tx_fifo (
    .clk   (REF_CLK),
    .rst_n (RSTN),
    .ce    (CE),
    .fen   (s.act_line.fen),
    .push  (tx_push),
    .wdata (WDATA[7:0]),
    .pop   (tx_pop),
    .rdata (tx_rdata),
    .count (tx_cnt),
    .full  (tx_full),
    .empty (tx_empty)
  );

  ast_fifo #(.W(12)) u_rx_fifo (
    .clk   (REF_CLK),
    .rst_n (RSTN),
    .ce    (CE),
    .fen   (s.act_line.fen),
    .push  (rx_push),
    .wdata (rx_wdata),
    .pop   (rx_pop),
    .rdata (rx_rdata),
    .count (rx_cnt),
    .full  (rx_full),
    .empty (rx_empty)
  );

  always_comb begin
    next_s = s;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_wdata = '0;
    last = s.ctrl.high_speed_sample_select ? AST_LAST8 : AST_LAST16;
    half = s.ctrl.high_speed_sample_select ? AST_HALF8 : AST_HALF16;
    top_bit = {1'b1, s.act_line.wlen};
    tx_end = tick && (s.tx_sub == last);
    rx_smp = tick && (s.rx_sub == last);
    rx_lvl = s.act_line.fen ? ast_lvl(s.lvl.rx) : 5'h01;
    tx_lvl = s.act_line.fen ? ast_lvl(s.lvl.tx) : 5'h00;
    busy = (s.tx_st != AST_TX_IDLE) || !tx_empty;

    // Register writes
    if (WR) begin
      case (ADDR)
        AST_OFS_DATA:  tx_push = 1'b1;
        AST_OFS_DIVI:  next_s.divi = WDATA[15:0];
        AST_OFS_DIVF:  next_s.divf = WDATA[5:0];
        AST_OFS_LINE: begin
          next_s.line = WDATA[7:0];
          next_s.act_line = WDATA[7:0];
          next_s.act_div = {s.divi, s.divf};
        end
        AST_OFS_CTRL:  next_s.ctrl = WDATA[7:0];
        AST_OFS_LEVEL: next_s.lvl = WDATA[5:0];
        AST_OFS_STAT:  next_s.oe_stat = 1'b0;
        default: ;
      endcase
    end

    // Register reads, data valid only in the following cycle
    next_s.rdata = 32'h0;
    if (RD) begin
      case (ADDR)
        AST_OFS_DATA: begin
          rx_pop = 1'b1;
          next_s.rdata = {20'h0, rx_rdata};
        end
        AST_OFS_FLAG:  next_s.rdata = {24'h0, tx_empty, rx_full, tx_full, rx_empty, busy, 3'h0};
        AST_OFS_DIVI:  next_s.rdata = {16'h0, s.divi};
        AST_OFS_DIVF:  next_s.rdata = {26'h0, s.divf};
        AST_OFS_LINE:  next_s.rdata = {24'h0, s.line};
        AST_OFS_CTRL:  next_s.rdata = {24'h0, s.ctrl};
        AST_OFS_LEVEL: next_s.rdata = {26'h0, s.lvl};
        AST_OFS_STAT:  next_s.rdata = {31'h0, s.oe_stat};
        default:       next_s.rdata = 32'h0;
      endcase
    end

    // Transmitter
    if (s.tx_st != AST_TX_IDLE && tick) begin
      next_s.tx_sub = tx_end ? 4'h0 : s.tx_sub + 4'h1;
    end
    case (s.tx_st)
      AST_TX_IDLE: begin
        next_s.txd = !s.act_line.brk;
        next_s.tx_sub = 4'h0;
        // Enable only gates the start of a new character
        if (!s.act_line.brk && s.ctrl.en && s.ctrl.transmit_path_enable && !tx_empty &&
            (!s.ctrl.ctsen || !CTS_N)) begin
          tx_pop = 1'b1;
          next_s.tx_sh = tx_rdata;
          next_s.tx_par = ast_par(tx_rdata, s.act_line);
          next_s.txd = 1'b0;
          next_s.tx_st = AST_TX_START;
        end
      end
      AST_TX_START: begin
        if (tx_end) begin
          next_s.tx_bit = 3'h0;
          next_s.txd = s.tx_sh[0];
          next_s.tx_st = AST_TX_DATA;
        end
      end
      AST_TX_DATA: begin
        if (tx_end) begin
          if (s.tx_bit == top_bit) begin
            next_s.tx_bit = 3'h0;
            if (s.act_line.pen) begin
              next_s.txd = s.tx_par;
              next_s.tx_st = AST_TX_PAR;
            end else begin
              next_s.txd = 1'b1;
              next_s.tx_st = AST_TX_STOP;
            end
          end else begin
            next_s.tx_bit = s.tx_bit + 3'h1;
            next_s.txd = s.tx_sh[next_s.tx_bit];
          end
        end
      end
      AST_TX_PAR: begin
        if (tx_end) begin
          next_s.txd = 1'b1;
          next_s.tx_st = AST_TX_STOP;
        end
      end
      AST_TX_STOP: begin
        if (tx_end) begin
          if (s.act_line.stp2 && s.tx_bit == 3'h0) begin
            next_s.tx_bit = 3'h1;
          end else begin
            next_s.txd = !s.act_line.brk;
            next_s.tx_st = AST_TX_IDLE;
          end
        end
      end
      default: begin
        next_s.txd = 1'b1;
        next_s.tx_st = AST_TX_IDLE;
      end
    endcase

    // Receiver
    next_s.rx_prev = RXD;
    if (s.rx_st != AST_RX_IDLE && tick) begin
      next_s.rx_sub = rx_smp ? 4'h0 : s.rx_sub + 4'h1;
    end
    case (s.rx_st)
      AST_RX_IDLE: begin
        next_s.rx_sub = 4'h0;
        if (s.ctrl.en && s.ctrl.receive_path_enable && s.rx_prev && !RXD) begin
          next_s.rx_st = AST_RX_START;
        end
      end
      AST_RX_START: begin
        if (tick && s.rx_sub == half) begin
          next_s.rx_sub = 4'h0;
          if (!RXD) begin
            next_s.rx_bit = 3'h0;
            next_s.rx_sh = 8'h00;
            next_s.rx_zero = 1'b1;
            next_s.rx_pe = 1'b0;
            next_s.rx_st = AST_RX_DATA;
          end else begin
            next_s.rx_st = AST_RX_IDLE;
          end
        end
      end
      AST_RX_DATA: begin
        if (rx_smp) begin
          next_s.rx_sh[s.rx_bit] = RXD;
          next_s.rx_zero = s.rx_zero && !RXD;
          if (s.rx_bit == top_bit) begin
            next_s.rx_st = s.act_line.pen ? AST_RX_PAR : AST_RX_STOP;
          end else begin
            next_s.rx_bit = s.rx_bit + 3'h1;
          end
        end
      end
      AST_RX_PAR: begin
        if (rx_smp) begin
          next_s.rx_pe = RXD != ast_par(s.rx_sh, s.act_line);
          next_s.rx_zero = s.rx_zero && !RXD;
          next_s.rx_st = AST_RX_STOP;
        end
      end
      AST_RX_STOP: begin
        if (rx_smp) begin
          rx_wdata.oe = s.oe_pend;
          rx_wdata.be = s.rx_zero && !RXD;
          rx_wdata.pe = s.rx_pe;
          rx_wdata.fe = !RXD;
          rx_wdata.data = s.rx_sh;
          if (rx_full && !rx_pop) begin
            next_s.oe_pend = 1'b1;
            next_s.oe_stat = 1'b1;
          end else begin
            rx_push = 1'b1;
            next_s.oe_pend = 1'b0;
          end
          next_s.rx_st = AST_RX_IDLE;
        end
      end
      default: next_s.rx_st = AST_RX_IDLE;
    endcase

    // Flow control, DMA requests and level outputs
    next_s.rts_n = s.ctrl.rtsen ? (rx_cnt >= rx_lvl) : !s.ctrl.rts;
    next_s.rx_sreq = !rx_empty;
    next_s.rx_breq = rx_cnt >= rx_lvl;
    next_s.tx_sreq = !tx_full;
    next_s.tx_breq = tx_cnt <= tx_lvl;
    next_s.rx_int = rx_cnt >= rx_lvl;
    next_s.tx_int = s.ctrl.eot ? !busy : (tx_cnt <= tx_lvl);
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s <= '0;
      s.ctrl <= AST_CTRL_RST;
      s.line <= AST_LINE_RST;
      s.act_line <= AST_LINE_RST;
      s.divi <= AST_DIVI_RST;
      s.divf <= AST_DIVF_RST;
      s.act_div <= {AST_DIVI_RST, AST_DIVF_RST};
      s.lvl <= AST_LEVEL_RST;
      s.tx_st <= AST_TX_IDLE;
      s.rx_st <= AST_RX_IDLE;
      s.rx_prev <= 1'b1;
      s.txd <= 1'b1;
      s.rts_n <= 1'b1;
    end else if (CE) begin
      s <= next_s;
    end
  end

  assign RDATA = s.rdata;
  assign TXD = s.txd;
  assign RTS_N = s.rts_n;
  assign DMA_RX_SREQ = s.rx_sreq;
  assign DMA_RX_BREQ = s.rx_breq;
  assign DMA_TX_SREQ = s.tx_sreq;
  assign DMA_TX_BREQ = s.tx_breq;
  assign RX_INT = s.rx_int;
  assign TX_INT = s.tx_int;
endmodule

// ### tb/ast_chk.sv
`timescale 1ns/100ps
module ast_chk
  import ast_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        RSTN,
  input wire logic [7:0]  ADDR,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        TXD,
  input wire logic        DMA_RX_SREQ,
  input wire logic        DMA_RX_BREQ,
  input wire logic        DMA_TX_SREQ,
  input wire logic        DMA_TX_BREQ,
  input wire logic        RX_INT
);
  // One bit time at divisor 2.0, less three clocks of start alignment
  localparam int MIN_RUN = 29;
  logic [7:0] low_run;
  logic [7:0] high_run;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      low_run  <= 8'h00;
      high_run <= 8'hFF;
    end else begin
      low_run  <= TXD ? 8'h00 : (low_run == 8'hFF ? low_run : low_run + 8'h01);
      high_run <= !TXD ? 8'h00 : (high_run == 8'hFF ? high_run : high_run + 8'h01);
    end
  end

  property p_rdata_idle; !$past(RD) |-> RDATA == 32'h00000000; endproperty
  property p_tx_burst; DMA_TX_BREQ |-> DMA_TX_SREQ; endproperty
  property p_rx_burst; DMA_RX_BREQ |-> DMA_RX_SREQ; endproperty
  property p_rx_int; RX_INT == DMA_RX_BREQ; endproperty
  property p_low_run; $rose(TXD) |-> low_run >= MIN_RUN; endproperty
  property p_high_run; $fell(TXD) |-> high_run >= MIN_RUN; endproperty
  property p_tx_full; $fell(DMA_TX_SREQ) |-> $past(WR, 2) && $past(ADDR, 2) == AST_OFS_DATA; endproperty
  property p_rx_empty; $fell(DMA_RX_SREQ) |-> $past(RD, 2) && $past(ADDR, 2) == AST_OFS_DATA; endproperty

  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
  a_tx_burst: assert property (p_tx_burst) else $error("tx burst without single");
  a_rx_burst: assert property (p_rx_burst) else $error("rx burst without single");
  a_rx_int: assert property (p_rx_int) else $error("rx interrupt differs from level");
  a_low_run: assert property (p_low_run) else $error("low level shorter than a bit");
  a_high_run: assert property (p_high_run) else $error("high level shorter than a bit");
  a_tx_full: assert property (p_tx_full) else $error("tx single dropped without write");
  a_rx_empty: assert property (p_rx_empty) else $error("rx single dropped without read");

  c_frame: cover property ($fell(TXD));
  c_tx_full: cover property ($fell(DMA_TX_SREQ));
  c_rx_burst: cover property ($rose(DMA_RX_BREQ));
endmodule

bind ast_transceiver ast_chk u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR), .WR(WR), .RD(RD),
  .RDATA(RDATA), .TXD(TXD), .DMA_RX_SREQ(DMA_RX_SREQ), .DMA_RX_BREQ(DMA_RX_BREQ),
  .DMA_TX_SREQ(DMA_TX_SREQ), .DMA_TX_BREQ(DMA_TX_BREQ), .RX_INT(RX_INT));

// ### tb/ast_peer.sv
`timescale 1ns/100ps
module ast_peer #(
  parameter int BIT = 32
) (
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic rts_n,
  output logic      rxd
);
  initial rxd = 1'b1;

  // Bit 0 of a frame is the start bit
  task automatic grab(input int n, output logic [11:0] f);
    f = 12'h000;
    while (txd !== 1'b0) @(posedge clk);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (BIT) @(posedge clk);
      f[i] = txd;
    end
  endtask

  task automatic send(input logic [11:0] f, input int n);
    while (rts_n !== 1'b0) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
    rxd <= 1'b1;
    @(posedge clk);
  endtask

  task automatic pulse(input int len);
    rxd <= 1'b0;
    repeat (len) @(posedge clk);
    rxd <= 1'b1;
  endtask
endmodule

// ### tb/ast_transceiver_bench.sv
`timescale 1ns/100ps
module ast_transceiver_bench
  import ast_pkg::*;
;
  logic        clk;
  logic        rstn;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic        cts_n;
  logic        ce;
  logic [31:0] rdata;
  logic        txd;
  logic        rxd;
  logic        rts_n;
  logic        rx_sreq;
  logic        rx_breq;
  logic        tx_sreq;
  logic        tx_breq;
  logic        rx_int;
  logic        tx_int;
  logic [31:0] v;
  logic [11:0] f;
  logic [11:0] g;
  int          n;
  int          bad_count = 0;
  int          checks_done = 0;
  int          lv [5] = '{2, 4, 8, 12, 14};
  logic [7:0]  fmts [5] = '{8'h60, 8'h06, 8'h2A, 8'hC6, 8'h82};

  ast_transceiver u_dut (.REF_CLK(clk), .RSTN(rstn), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .TXD(txd), .RXD(rxd), .CTS_N(cts_n), .RTS_N(rts_n), .DMA_RX_SREQ(rx_sreq),
    .DMA_RX_BREQ(rx_breq), .DMA_TX_SREQ(tx_sreq), .DMA_TX_BREQ(tx_breq), .RX_INT(rx_int), .TX_INT(tx_int));
  ast_peer #(.BIT(32)) u_peer (.clk(clk), .txd(txd), .rts_n(rts_n), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] got);
    checks_done++;
    if (got !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
    chk(s, e, v & m);
  endtask

  task automatic cfg(input logic [7:0] line, input logic [7:0] ctrl);
    wr_reg(AST_OFS_CTRL, 32'h00000038);
    wr_reg(AST_OFS_LINE, {24'h0, line});
    wr_reg(AST_OFS_CTRL, {24'h0, ctrl});
  endtask

  // Start, data LSB first, parity, stop bits
  function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] l, output int k);
    logic [11:0] r;
    logic        x;
    r = 12'h000;
    x = 1'b0;
    k = 1;
    for (int i = 0; i < 5 + int'(l[6:5]); i++) begin
      r[k] = d[i];
      x    = x ^ d[i];
      k++;
    end
    if (l[1]) begin
      r[k] = l[7] ? ~l[2] : (l[2] ? x : ~x);
      k++;
    end
    r[k]     = 1'b1;
    r[k + 1] = l[3];
    k        = k + 1 + int'(l[3]);
    return r;
  endfunction

  task automatic tx_exp(input logic [7:0] d, input logic [7:0] line);
    f = frame(d, line, n);
    u_peer.grab(n, g);
    chk("txframe", {20'h0, f}, {20'h0, g});
  endtask

  task automatic tx_one(input logic [7:0] d, input logic [7:0] line);
    wr_reg(AST_OFS_DATA, {24'h0, d});
    tx_exp(d, line);
  endtask

  task automatic rx_one(input logic [11:0] fr, input int k, input logic [11:0] m, input logic [11:0] e);
    u_peer.send(fr, k);
    repeat (4) @(posedge clk);
    rd_chk(AST_OFS_DATA, {20'h0, m}, {20'h0, e}, "rxword");
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    results();
  end

  initial begin
    rstn  = 1'b0;
    addr  = 8'h00;
    wdata = 32'h00000000;
    wr    = 1'b0;
    rd    = 1'b0;
    cts_n = 1'b0;
    ce    = 1'b1;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk("pins", 32'h37, {24'h0, rx_sreq, rx_breq, tx_sreq, tx_breq, rx_int, tx_int, rts_n, txd});
    @(posedge clk);
    rd_chk(AST_OFS_CTRL, 32'hFF, 32'h18, "ctrl");
    rd_chk(AST_OFS_LEVEL, 32'h3F, 32'h12, "level");
    rd_chk(AST_OFS_FLAG, 32'hF8, 32'h90, "flag");
    rd_chk(8'h24, 32'hFFFFFFFF, 32'h0, "unmapped");
    // A write while the enable is low must be lost
    ce <= 1'b0;
    wr_reg(AST_OFS_DIVI, 32'h00000005);
    ce <= 1'b1;
    rd_chk(AST_OFS_DIVI, 32'hFFFF, 32'h0, "frozen");
    wr_reg(AST_OFS_DIVI, 32'h00000002);
    wr_reg(AST_OFS_DIVF, 32'h00000000);
    for (int i = 0; i < 5; i++) begin
      cfg(fmts[i], 8'h39);
      tx_one(8'h9C + 8'(i * 37), fmts[i]);
    end
    wr_reg(AST_OFS_CTRL, 32'h00000038);
    wr_reg(AST_OFS_DIVI, 32'h00000004);
    wr_reg(AST_OFS_CTRL, 32'h00000039);
    tx_one(8'h5B, 8'h82);
    wr_reg(AST_OFS_DIVI, 32'h00000002);
    fork
      tx_one(8'hC3, 8'h82);
      begin
        repeat (120) @(posedge clk);
        wr_reg(AST_OFS_CTRL, 32'h00000038);
      end
    join
    cts_n <= 1'b1;
    cfg(8'h60, 8'hB9);
    wr_reg(AST_OFS_DATA, 32'h0000007E);
    repeat (100) @(posedge clk);
    chk("held", 32'h1, {31'h0, txd});
    chk("txsreq", 32'h0, {31'h0, tx_sreq});
    rd_chk(AST_OFS_FLAG, 32'hA0, 32'h20, "txfull");
    cts_n <= 1'b0;
    tx_exp(8'h7E, 8'h60);
    cts_n <= 1'b1;
    cfg(8'h70, 8'hB9);
    for (int i = 0; i < 17; i++) wr_reg(AST_OFS_DATA, {24'h0, 8'h40 + 8'(i)});
    rd_chk(AST_OFS_FLAG, 32'hA0, 32'h20, "txfull16");
    chk("txburst", 32'h0, {31'h0, tx_breq});
    cts_n <= 1'b0;
    for (int i = 0; i < 16; i++) tx_exp(8'h40 + 8'(i), 8'h70);
    repeat (64) @(posedge clk);
    rd_chk(AST_OFS_FLAG, 32'h80, 32'h80, "txempty");
    cfg(8'h61, 8'h39);
    repeat (100) @(posedge clk);
    chk("break", 32'h0, {31'h0, txd});
    cfg(8'h60, 8'h39);
    repeat (5) @(posedge clk);
    chk("unbreak", 32'h1, {31'h0, txd});
    f = frame(8'h5A, 8'h60, n);
    rx_one(f, n, 12'hFFF, 12'h05A);
    rx_one(f ^ 12'h200, n, 12'hFFF, 12'h15A);
    rx_one(12'h000, 10, 12'h4FF, 12'h400);
    u_peer.pulse(6);
    repeat (64) @(posedge clk);
    rd_chk(AST_OFS_FLAG, 32'h10, 32'h10, "glitch");
    cfg(8'h66, 8'h39);
    f = frame(8'h5A, 8'h66, n);
    rx_one(f, n, 12'hFFF, 12'h05A);
    rx_one(f ^ 12'h200, n, 12'hFFF, 12'h25A);
    cfg(8'h60, 8'h39);
    f = frame(8'h11, 8'h60, n);
    u_peer.send(f, n);
    repeat (4) @(posedge clk);
    chk("rxint", 32'h1, {31'h0, rx_int});
    f = frame(8'h22, 8'h60, n);
    u_peer.send(f, n);
    rd_chk(AST_OFS_STAT, 32'h1, 32'h1, "overrun");
    rx_one(f, 0, 12'hFFF, 12'h011);
    f = frame(8'h33, 8'h60, n);
    rx_one(f, n, 12'hFFF, 12'h833);
    wr_reg(AST_OFS_STAT, 32'h00000000);
    rd_chk(AST_OFS_STAT, 32'h1, 32'h0, "ovclear");
    // Eight ticks a bit at divisor 4.0 keeps the same bit time
    wr_reg(AST_OFS_DIVI, 32'h00000004);
    cfg(8'h60, 8'h3F);
    wr_reg(AST_OFS_DATA, 32'h000000A5);
    repeat (2) @(posedge clk);
    chk("eot", 32'h0, {31'h0, tx_int});
    tx_exp(8'hA5, 8'h60);
    f = frame(8'h3C, 8'h60, n);
    rx_one(f, n, 12'hFFF, 12'h03C);
    wr_reg(AST_OFS_DIVI, 32'h00000002);
    cfg(8'h70, 8'h79);
    for (int s = 0; s < 5; s++) begin
      wr_reg(AST_OFS_LEVEL, {26'h0, 3'(s), 3'h2});
      for (int i = 0; i < lv[s]; i++) begin
        chk("rxbelow", 32'h0, {31'h0, rx_breq});
        f = frame(8'(i), 8'h70, n);
        u_peer.send(f, n);
        repeat (4) @(posedge clk);
      end
      chk("rxburst", 32'h1, {31'h0, rx_breq});
      chk("rts", 32'h1, {31'h0, rts_n});
      for (int i = 0; i < lv[s]; i++) rd_chk(AST_OFS_DATA, 32'hFFF, {24'h0, 8'(i)}, "rxfifo");
    end
    cfg(8'h70, 8'h39);
    for (int i = 0; i < 17; i++) begin
      f = frame(8'hE0 + 8'(i), 8'h70, n);
      u_peer.send(f, n);
    end
    repeat (4) @(posedge clk);
    rd_chk(AST_OFS_STAT, 32'h1, 32'h1, "fifoover");
    for (int i = 0; i < 16; i++) rd_chk(AST_OFS_DATA, 32'hFFF, {24'h0, 8'hE0 + 8'(i)}, "rxdepth");
    rd_chk(AST_OFS_FLAG, 32'h10, 32'h10, "rxempty");
    results();
  end
endmodule
